/* src/aca_pkg.sv */
/*
 * aca_pkg: register map, field layouts, reset values and types shared by
 * the accumulator arithmetic slice.
 * assumes: one 100 MHz clock, registers reached over axi4-lite, 32-bit data.
 */
package aca_pkg;
  // axi4-lite register byte offsets
  localparam logic [7:0] OFF_ACC_A_LO = 8'h00;
  localparam logic [7:0] OFF_ACC_A_EXT = 8'h04;
  localparam logic [7:0] OFF_ACC_B_LO = 8'h08;
  localparam logic [7:0] OFF_ACC_B_EXT = 8'h0C;
  localparam logic [7:0] OFF_Y_PAIR = 8'h10;
  localparam logic [7:0] OFF_CCB = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MOVE_DATA = 8'h24;
  // field positions
  localparam int CTRL_SAT_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  // values and counts
  localparam logic [35:0] ACC_MOST_NEG = 36'h8_0000_0000;
  localparam logic [35:0] ACC_MOST_POS = 36'h7_FFFF_FFFF;
  localparam logic [31:0] LONG_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] LONG_MOST_POS = 32'h7FFF_FFFF;
  localparam logic [2:0] BASE_CLOCKS = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [35:0] ACC_RST = 36'h0_0000_0000;
  localparam logic [31:0] Y_RST = 32'h0000_0000;
  localparam logic [7:0] CCB_RST = 8'h00;
  localparam logic SAT_RST = 1'b0;

  // condition code byte, msb first: bit 7 size .. bit 0 carry
  typedef struct packed {
    logic size_flag;
    logic limit;
    logic extension;
    logic unnorm;
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } aca_ccb_t;

  // command word, low five bits of the command register
  typedef struct packed {
    logic [1:0] parallel_move_extra_clocks;
    logic move_en;
    logic dest_b;
    logic adc_op;
  } aca_cmd_t;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} aca_state_t;
endpackage : aca_pkg

/* src/aca_alu.sv */
/* aca_alu: magnitude and add-long-with-carry on two 36-bit accumulators,
 * with an optional parallel move read-out and the condition code byte.
 * assumes: software drives it as an axi4-lite master, one clock, sync reset. */
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - magnitude_op replaces the accumulator by its 36-bit two's complement when negative.
// - the most negative accumulator value flags overflow and is kept, not limited.
// - magnitude_op sets limit, extension, negative, zero and overflow from its result.
// - magnitude_op takes two clocks plus the parallel move extra clocks.
// - a parallel move reads the accumulator as it was before the operation.
// - add-with-carry adds the sign-extended y pair and carry into the accumulator.
// - carry enters the lsb of the sum and the y pair is left untouched.
// - with saturation_enable set an overflowed sum is saturated, not wrapped.
// - add-with-carry sets carry from the carry or borrow out of 36 bits.
// - add-with-carry sets zero, overflow, limit and negative from its result.
// - add-with-carry takes y with either accumulator and runs in two clocks plus the parallel move extra clocks.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none
module aca_alu (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import aca_pkg::*;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge
  // a move out of a 36-bit accumulator is limited to the 32-bit range
  function automatic logic [31:0] lim32(input logic [35:0] v);
    return (v[35:31] == 5'h00 || v[35:31] == 5'h1F) ? v[31:0] :
      (v[35] ? LONG_MOST_NEG : LONG_MOST_POS);
  endfunction : lim32
  //////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic awready_r, awready_nxt, wready_r, wready_nxt, aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt, bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt, wr_fire, rd_ok;
  logic [7:0] awaddr_r, awaddr_nxt, wr_addr, rd_addr;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_mux;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  // core state
  aca_state_t state_r, state_nxt;
  aca_cmd_t cmd_r, cmd_nxt, cmd_in;
  aca_ccb_t ccb_r, ccb_nxt;
  logic [35:0] acc_a_r, acc_a_nxt, acc_b_r, acc_b_nxt, opnd_r, opnd_nxt, sel_acc;
  logic [35:0] abs_res, add_res, res;
  logic [36:0] sum37;
  logic [31:0] y_r, y_nxt, move_r, move_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic sat_r, sat_nxt, cin_r, cin_nxt, mvlim_r, mvlim_nxt, start, commit;
  logic abs_ovf, add_ovf, ovf, busy;
  assign wr_addr = {awaddr_r[7:2], 2'b00};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign busy = (state_r == ST_EXEC);
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      OFF_ACC_A_LO: rd_mux = acc_a_r[31:0];
      OFF_ACC_A_EXT: rd_mux = {28'h000_0000, acc_a_r[35:32]};
      OFF_ACC_B_LO: rd_mux = acc_b_r[31:0];
      OFF_ACC_B_EXT: rd_mux = {28'h000_0000, acc_b_r[35:32]};
      OFF_Y_PAIR: rd_mux = y_r;
      OFF_CCB: rd_mux = {24'h00_0000, ccb_r};
      OFF_CTRL: rd_mux = {31'h0000_0000, sat_r};
      OFF_CMD: rd_mux = {27'h000_0000, cmd_r};
      OFF_STATUS: rd_mux = {31'h0000_0000, busy};
      OFF_MOVE_DATA: rd_mux = move_r;
      default: rd_ok = 1'b0;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken in either order
  always_comb begin
    aw_full_nxt = aw_full_r | (s_axi_awvalid & awready_r);
    awaddr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
    w_full_nxt = w_full_r | (s_axi_wvalid & wready_r);
    wdata_nxt = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    bresp_nxt = bresp_r;
    wr_fire = aw_full_r & w_full_r & ~bvalid_r;
    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_addr <= OFF_MOVE_DATA) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
    rvalid_nxt = rvalid_r & ~s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid & arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_mux;
      rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    arready_nxt = ~rvalid_nxt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  //////////////////////////////////////////////////////////////////////////////
  // datapath, computed from the operand frozen at start
  always_comb begin
    abs_ovf = (opnd_r == ACC_MOST_NEG);
    abs_res = (opnd_r[35] && !abs_ovf) ? 36'(~opnd_r + 36'h0_0000_0001) : opnd_r;
    sum37 = {1'b0, opnd_r} + {1'b0, {4{y_r[31]}}, y_r} + {36'h0_0000_0000, cin_r};
    add_ovf = (opnd_r[35] == y_r[31]) && (sum37[35] != opnd_r[35]);
    add_res = (sat_r && add_ovf) ? (opnd_r[35] ? ACC_MOST_NEG : ACC_MOST_POS) : sum37[35:0];
    res = cmd_r.adc_op ? add_res : abs_res;
    ovf = cmd_r.adc_op ? add_ovf : abs_ovf;
  end
  //////////////////////////////////////////////////////////////////////////////
  // sequencer and register file; writes are ignored while an operation runs,
  // so a software write never races a hardware flag update
  always_comb begin
    cmd_in = aca_cmd_t'(wdata_r[4:0]);
    sel_acc = cmd_in.dest_b ? acc_b_r : acc_a_r;
    start = wr_fire && wr_addr == OFF_CMD && !busy && wstrb_r[0];
    commit = busy && cnt_r == 3'h0;
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    ccb_nxt = ccb_r;
    acc_a_nxt = acc_a_r;
    acc_b_nxt = acc_b_r;
    y_nxt = y_r;
    sat_nxt = sat_r;
    opnd_nxt = opnd_r;
    cin_nxt = cin_r;
    cnt_nxt = cnt_r;
    move_nxt = move_r;
    mvlim_nxt = mvlim_r;
    if (wr_fire && !busy) begin
      case (wr_addr)
        OFF_ACC_A_LO: acc_a_nxt[31:0] = merge(acc_a_r[31:0], wdata_r, wstrb_r);
        OFF_ACC_A_EXT: acc_a_nxt[35:32] = wstrb_r[0] ? wdata_r[3:0] : acc_a_r[35:32];
        OFF_ACC_B_LO: acc_b_nxt[31:0] = merge(acc_b_r[31:0], wdata_r, wstrb_r);
        OFF_ACC_B_EXT: acc_b_nxt[35:32] = wstrb_r[0] ? wdata_r[3:0] : acc_b_r[35:32];
        OFF_Y_PAIR: y_nxt = merge(y_r, wdata_r, wstrb_r);
        OFF_CCB: ccb_nxt = wstrb_r[0] ? aca_ccb_t'(wdata_r[7:0]) : ccb_r;
        OFF_CTRL: sat_nxt = wstrb_r[0] ? wdata_r[CTRL_SAT_BIT] : sat_r;
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: if (start) begin
        state_nxt = ST_EXEC;
        cmd_nxt = cmd_in;
        opnd_nxt = sel_acc;
        cin_nxt = ccb_r.carry;
        cnt_nxt = BASE_CLOCKS - 3'h1 + {1'b0, cmd_in.parallel_move_extra_clocks};
        mvlim_nxt = cmd_in.move_en && (lim32(sel_acc) != sel_acc[31:0]);
        move_nxt = cmd_in.move_en ? lim32(sel_acc) : move_r;
      end
      ST_EXEC: begin
        cnt_nxt = cnt_r - 3'h1;
        if (commit) begin
          state_nxt = ST_IDLE;
          acc_a_nxt = cmd_r.dest_b ? acc_a_r : res;
          acc_b_nxt = cmd_r.dest_b ? res : acc_b_r;
          ccb_nxt.carry = cmd_r.adc_op ? sum37[36] : ccb_r.carry;
          ccb_nxt.overflow = ovf;
          ccb_nxt.zero = (res == ACC_RST);
          ccb_nxt.negative = res[35];
          ccb_nxt.unnorm = ~(res[31] ^ res[30]);
          ccb_nxt.extension = ~(res[35:31] == 5'h00 || res[35:31] == 5'h1F);
          ccb_nxt.limit = ccb_r.limit | ovf | mvlim_r;
          ccb_nxt.size_flag = ccb_r.size_flag | (cmd_r.move_en & (opnd_r[30] ^ opnd_r[29]));
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cmd_r <= aca_cmd_t'(5'h00);
      ccb_r <= aca_ccb_t'(CCB_RST);
      acc_a_r <= ACC_RST;
      acc_b_r <= ACC_RST;
      y_r <= Y_RST;
      sat_r <= SAT_RST;
      opnd_r <= ACC_RST;
      cin_r <= 1'b0;
      cnt_r <= 3'h0;
      move_r <= 32'h0000_0000;
      mvlim_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      ccb_r <= ccb_nxt;
      acc_a_r <= acc_a_nxt;
      acc_b_r <= acc_b_nxt;
      y_r <= y_nxt;
      sat_r <= sat_nxt;
      opnd_r <= opnd_nxt;
      cin_r <= cin_nxt;
      cnt_r <= cnt_nxt;
      move_r <= move_nxt;
      mvlim_r <= mvlim_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  abs_value_a: assert property (commit && !cmd_r.adc_op && !cmd_r.dest_b && !abs_ovf |=>
    acc_a_r == (opnd_r[35] ? 36'(~opnd_r + 36'h0_0000_0001) : opnd_r)) else $error("abs value");
  abs_overflow_a: assert property (commit && !cmd_r.adc_op && abs_ovf |=>
    ccb_r.overflow && ccb_r.limit && (cmd_r.dest_b ? acc_b_r : acc_a_r) == ACC_MOST_NEG)
    else $error("abs overflow");
  abs_flags_a: assert property (commit && !cmd_r.adc_op |=>
    ccb_r.negative == (cmd_r.dest_b ? acc_b_r[35] : acc_a_r[35]) &&
    ccb_r.zero == ((cmd_r.dest_b ? acc_b_r : acc_a_r) == ACC_RST)) else $error("abs flags");
  op_timing_a: assert property (start && cmd_in.parallel_move_extra_clocks == 2'h0 |=>
    busy [*2] ##1 !busy) else $error("op timing");
  move_source_a: assert property (start && cmd_in.move_en |=>
    move_r == lim32($past(sel_acc))) else $error("move source");
  adc_sum_a: assert property (commit && cmd_r.adc_op && !cmd_r.dest_b && !sat_r |=>
    acc_a_r == 36'($past(opnd_r) + {{4{y_r[31]}}, y_r} + 36'($past(cin_r))))
    else $error("adc sum");
  y_kept_a: assert property (commit && cmd_r.adc_op |=> y_r == $past(y_r))
    else $error("y pair changed");
  adc_saturate_a: assert property (commit && cmd_r.adc_op && sat_r && add_ovf |=>
    (cmd_r.dest_b ? acc_b_r : acc_a_r) == ($past(opnd_r[35]) ? ACC_MOST_NEG : ACC_MOST_POS))
    else $error("adc saturate");
  adc_carry_a: assert property (commit && cmd_r.adc_op |=> ccb_r.carry == $past(sum37[36]))
    else $error("adc carry");
  adc_flags_a: assert property (commit && cmd_r.adc_op && add_ovf |=>
    ccb_r.overflow && ccb_r.limit && !ccb_r.zero) else $error("adc flags");
endmodule : aca_alu
`default_nettype wire

/* verification/aca_host.sv */
/*
 * aca_host: axi4-lite master standing in for the decoder and program controller.
 * assumes: one clock; the bench calls wr and rd right after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module aca_host (
  // clock
  input wire logic aclk,
  // write side
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read side
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // answer readies held high: avoids a double drive between back-to-back calls
  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // only register transfers, never a duplicate parallel read destination
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    logic b_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (b_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        b_p = 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_p;
    logic r_p;
    ar_p = 1'b1;
    r_p = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (r_p) begin
      @(posedge aclk);
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        r_p = 1'b0;
      end
    end
  endtask : rd
endmodule : aca_host
`default_nettype wire

/* verification/tb_top.sv */
/*
 * tb_top: register-level tests of the accumulator slice through the host model.
 * assumes: aca_pkg, aca_alu and aca_host compiled first; 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  import aca_pkg::*;
  logic aclk;
  logic aresetn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] a;

  aca_alu aca_alu_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  aca_host aca_host_i (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    aca_host_i.rd(ad, d, r);
    `CHK("rdata", e, d)
    `CHK("rresp", er, r)
  endtask : rdc

  task automatic wrc(input logic [7:0] ad, input logic [31:0] dt);
    aca_host_i.wr(ad, dt, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wrc

  // load operands, start, wait idle, read back result, flags and y pair
  task automatic run(input logic [4:0] c, input logic [35:0] acc, input logic [31:0] y,
      input logic s, input logic [7:0] c0, input logic [35:0] ea, input logic [7:0] ec);
    logic [7:0] b;
    int n;
    b = c[1] ? OFF_ACC_B_LO : OFF_ACC_A_LO;
    wrc(b, acc[31:0]);
    wrc(b + 8'h04, {28'h000_0000, acc[35:32]});
    wrc(OFF_Y_PAIR, y);
    wrc(OFF_CCB, {24'h00_0000, c0});
    wrc(OFF_CTRL, {31'h0000_0000, s});
    wrc(OFF_CMD, {27'h000_0000, c});
    if (c[4:3] == 2'h3) begin
      rdc(OFF_STATUS, 32'h0000_0001, RESP_OKAY); // still busy three edges on
      wrc(OFF_CCB, 32'h0000_00ff); // refused while busy, still answered okay
    end
    n = 0;
    do begin
      aca_host_i.rd(OFF_STATUS, d, r);
      n++;
    end while (d[STATUS_BUSY_BIT] !== 1'b0 && n < 20);
    `CHK("busy", 1'b0, d[STATUS_BUSY_BIT])
    rdc(b, ea[31:0], RESP_OKAY);
    aca_host_i.rd(b + 8'h04, d, r);
    `CHK("acc ext", ea[35:32], d[3:0])
    rdc(OFF_CCB, {24'h00_0000, ec}, RESP_OKAY);
    rdc(OFF_Y_PAIR, y, RESP_OKAY);
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (a = 8'h00; a <= OFF_MOVE_DATA; a += 8'h04) rdc(a, 32'h0000_0000, RESP_OKAY);
    rdc(8'h28, 32'h0000_0000, RESP_SLVERR);
    aca_host_i.wr(8'h28, 32'h0000_0001, r);
    `CHK("bresp unmapped", RESP_SLVERR, r)
    // magnitude on a, three extra move clocks, move source fits in 32 bits: sets only unnorm
    run(5'h1c, 36'hf_ffff_fff2, 32'h0000_0000, 1'b0, 8'h00, 36'h0_0000_000e, 8'h10);
    rdc(OFF_MOVE_DATA, 32'hffff_fff2, RESP_OKAY);
    // magnitude on b, one extra move clock, move source needs limiting: sets limit, size, extension and unnorm
    run(5'h0e, 36'h0_c000_0000, 32'h0000_0000, 1'b0, 8'h00, 36'h0_c000_0000, 8'hf0);
    rdc(OFF_MOVE_DATA, LONG_MOST_POS, RESP_OKAY);
    run(5'h02, ACC_MOST_NEG, 32'h0000_0000, 1'b0, 8'h00, ACC_MOST_NEG, 8'h7a);
    run(5'h01, 36'h0_2000_8000, 32'h2000_8000, 1'b0, 8'h01, 36'h0_4001_0001, 8'h00);
    run(5'h03, 36'h0_0000_0001, 32'hffff_ffff, 1'b0, 8'h00, 36'h0_0000_0000, 8'h15);
    run(5'h01, ACC_MOST_POS, 32'h0000_0001, 1'b0, 8'h00, ACC_MOST_NEG, 8'h7a);
    run(5'h01, ACC_MOST_POS, 32'h0000_0001, 1'b1, 8'h00, ACC_MOST_POS, 8'h72);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
